// ---- irq_pkg.sv ----
// Shared constants, types and helpers for both ends of the interrupt link
package irq_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int PORT_W = 4;

    // File register addresses seen on the link
    localparam logic [7:0] IRQ_CTRL_LO_ADDR = 8'h0b;
    localparam logic [7:0] IRQ_CTRL_HI_ADDR = 8'h8b;
    localparam logic [7:0] PFLAG_ONE_ADDR = 8'h0c;
    localparam logic [7:0] PENABLE_ONE_ADDR = 8'h8c;
    localparam logic [7:0] CONV_RESULT_ADDR = 8'h1e;
    localparam logic [7:0] CONV_CTRL_ADDR = 8'h1f;

    // Control register fields
    localparam int GLOBAL_EN_BIT = 7;
    localparam int CONV_EN_BIT = 6;
    localparam int TIMER_EN_BIT = 5;
    localparam int PIN_EN_BIT = 4;
    localparam int PORT_EN_BIT = 3;
    localparam int TIMER_FLAG_BIT = 2;
    localparam int PIN_FLAG_BIT = 1;
    localparam int PORT_FLAG_BIT = 0;
    // Peripheral flag/enable and conversion control fields
    localparam int CONV_FLAG_BIT = 6;
    localparam logic [7:0] PERIPH_MASK = 8'h40;
    localparam int GO_BIT = 2;
    localparam int CONV_ON_BIT = 0;

    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;

    // Instruction timing of the core
    localparam int INSTR_CLKS = 4;
    localparam int DUMMY_CYCLES = 2;
    localparam int STACK_DEPTH = 8;

    // Settle time after a conversion, two bit periods
    localparam int CLK_MHZ = 200;
    localparam int CONV_BIT_PERIOD_NS = 2000;
    localparam int CONV_BIT_PERIOD_CLKS = (CONV_BIT_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CLKS = 2 * CONV_BIT_PERIOD_CLKS;

    // Core user register map
    localparam logic [2:0] UREG_FADDR = 3'h0;
    localparam logic [2:0] UREG_FDATA = 3'h1;
    localparam logic [2:0] UREG_CTRL = 3'h2;
    localparam logic [2:0] UREG_STATUS = 3'h3;
    localparam logic [2:0] UREG_PC_LO = 3'h4;
    localparam logic [2:0] UREG_PC_HI = 3'h5;
    localparam int CTL_READ = 0;
    localparam int CTL_RETURN = 1;
    localparam int CTL_SAFE_OFF = 2;

    typedef enum logic [1:0] {SQ_RUN, SQ_DUMMY} seq_type;
    typedef enum logic [1:0] {BS_IDLE, BS_READ, BS_WAIT, BS_CHECK} bus_type;

    // Control register answers at both mirror addresses
    function automatic logic is_irq_ctrl(input logic [7:0] addr);
        return (addr == IRQ_CTRL_LO_ADDR) || (addr == IRQ_CTRL_HI_ADDR);
    endfunction
endpackage

// ---- irq_link_if.sv ----
// Link between the interrupt controller and the processor core
interface irq_link_if;
    logic [7:0] f_addr;
    logic [7:0] f_wdata;
    logic [7:0] f_rdata;
    logic f_we;
    logic f_re;
    logic irq_req;
    logic irq_ack;
    logic isr_return;
    logic conv_done_evt;
    logic [irq_pkg::PC_W-1:0] vector;

    modport dev(
        input f_addr, f_wdata, f_we, f_re, irq_ack, isr_return,
        output f_rdata, irq_req, conv_done_evt, vector
    );
    modport core(
        output f_addr, f_wdata, f_we, f_re, irq_ack, isr_return,
        input f_rdata, irq_req, conv_done_evt, vector
    );
endinterface

// ---- pin_sync3.sv ----
// Three-stage pin synchroniser with agreement filter
module pin_sync3 #(
    parameter int WIDTH = 5
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] stable
);
    logic [WIDTH-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
    logic [WIDTH-1:0] stable_q, stable_d;

    // Stage shift; a bit moves once stages two and three agree
    always_comb begin
        s1_d = pins;
        s2_d = s1_q;
        s3_d = s2_q;
        stable_d = (stable_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stable_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            stable_q <= stable_d;
        end
    end

    assign stable = stable_q;
endmodule

// ---- irq_ctrl_dev.sv ----
// Interrupt controller end: source flags, enables, request and conversion
// Functional notes
// - Four sources: pin, timer, port, conversion
// - Flags set regardless of any enable
// - Global enable bit gates all requests
// - Enabled pending flag requests vector immediately
// - Reset clears the global enable
// - Return from service sets global enable
// - Accept clears enable, stacks, vectors 0004h
// - Software clears flags before re-enabling
// - Pin event latency three or four cycles
// - Core flags in control, peripheral separate
// - Software re-tests global clear until clear
// - Conversion end loads result, clears go
// - Wait two bit periods before acquiring
// - Software sequence for interrupt-driven conversion
// - Control register mirrored, fixed bit layout
module irq_ctrl_dev (
    input wire logic mclk,
    input wire logic resetn,
    irq_link_if.dev link,
    input wire logic ext_irq_pin,
    input wire logic [irq_pkg::PORT_W-1:0] port_b_upper_pins,
    input wire logic timer_ovf,
    input wire logic conv_done,
    input wire logic [irq_pkg::DATA_W-1:0] conv_result,
    output logic conv_start,
    output logic conv_power
);
    localparam int PW = irq_pkg::PORT_W;

    logic [PW:0] pins_stable;
    logic [PW:0] prev_q, prev_d;
    logic [7:0] irq_control_reg_q, irq_control_reg_d;
    logic [7:0] periph_flag_reg_one_q, periph_flag_reg_one_d;
    logic [7:0] periph_enable_reg_one_q, periph_enable_reg_one_d;
    logic [7:0] conv_result_reg_q, conv_result_reg_d;
    logic [7:0] conv_control_zero_q, conv_control_zero_d;
    logic [7:0] rdata_q, rdata_d;
    logic start_q, start_d;
    logic evt_q, evt_d;
    logic ext_rise, port_chg;
    logic wr_ctrl, wr_flag, wr_en, wr_conv;
    logic core_req, periph_req;

    // Pin inputs arrive from outside the clock domain
    pin_sync3 #(
        .WIDTH(PW + 1)
    ) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .pins({ext_irq_pin, port_b_upper_pins}),
        .stable(pins_stable)
    );

    // Edge and change detection on filtered pins
    assign ext_rise = pins_stable[PW] & ~prev_q[PW];
    assign port_chg = |(pins_stable[PW-1:0] ^ prev_q[PW-1:0]);

    // Write decode for each file register except the conversion result
    assign wr_ctrl = link.f_we && irq_pkg::is_irq_ctrl(link.f_addr);
    assign wr_flag = link.f_we && (link.f_addr == irq_pkg::PFLAG_ONE_ADDR);
    assign wr_en = link.f_we && (link.f_addr == irq_pkg::PENABLE_ONE_ADDR);
    assign wr_conv = link.f_we && (link.f_addr == irq_pkg::CONV_CTRL_ADDR);

    // Control register: software write, then hardware flag sets win
    always_comb begin
        irq_control_reg_d = irq_control_reg_q;
        if (wr_ctrl) begin
            irq_control_reg_d = link.f_wdata;
        end
        if (timer_ovf) begin
            irq_control_reg_d[irq_pkg::TIMER_FLAG_BIT] = 1'b1;
        end
        if (ext_rise) begin
            irq_control_reg_d[irq_pkg::PIN_FLAG_BIT] = 1'b1;
        end
        if (port_chg) begin
            irq_control_reg_d[irq_pkg::PORT_FLAG_BIT] = 1'b1;
        end
        // Accept closes the gate; return from service reopens it
        if (link.irq_ack) begin
            irq_control_reg_d[irq_pkg::GLOBAL_EN_BIT] = 1'b0;
        end else if (link.isr_return) begin
            irq_control_reg_d[irq_pkg::GLOBAL_EN_BIT] = 1'b1;
        end
    end

    // Peripheral flag and enable registers, one implemented bit each
    always_comb begin
        periph_flag_reg_one_d = periph_flag_reg_one_q;
        periph_enable_reg_one_d = periph_enable_reg_one_q;
        if (wr_flag) begin
            periph_flag_reg_one_d = link.f_wdata & irq_pkg::PERIPH_MASK;
        end
        if (wr_en) begin
            periph_enable_reg_one_d = link.f_wdata & irq_pkg::PERIPH_MASK;
        end
        if (conv_done) begin
            periph_flag_reg_one_d[irq_pkg::CONV_FLAG_BIT] = 1'b1;
        end
    end

    // Conversion control and result
    always_comb begin
        conv_control_zero_d = conv_control_zero_q;
        conv_result_reg_d = conv_result_reg_q;
        start_d = 1'b0;
        evt_d = conv_done;
        if (wr_conv) begin
            conv_control_zero_d = link.f_wdata;
            // Start only on a fresh go while the converter is powered
            start_d = link.f_wdata[irq_pkg::GO_BIT]
                & ~conv_control_zero_q[irq_pkg::GO_BIT]
                & link.f_wdata[irq_pkg::CONV_ON_BIT];
        end
        if (conv_done) begin
            conv_result_reg_d = conv_result;
            // A go written in the same cycle that starts a conversion is kept
            if (!(start_d)) begin
                conv_control_zero_d[irq_pkg::GO_BIT] = 1'b0;
            end
        end
    end

    // Remember last filtered pin levels
    always_comb begin
        prev_d = pins_stable;
    end

    // Read mux, answer one cycle after the read strobe
    always_comb begin
        rdata_d = irq_pkg::REG_RST;
        if (link.f_re) begin
            if (irq_pkg::is_irq_ctrl(link.f_addr)) begin
                rdata_d = irq_control_reg_q;
            end else begin
                case (link.f_addr)
                    irq_pkg::PFLAG_ONE_ADDR: begin
                        rdata_d = periph_flag_reg_one_q;
                    end
                    irq_pkg::PENABLE_ONE_ADDR: begin
                        rdata_d = periph_enable_reg_one_q;
                    end
                    irq_pkg::CONV_RESULT_ADDR: begin
                        rdata_d = conv_result_reg_q;
                    end
                    irq_pkg::CONV_CTRL_ADDR: begin
                        rdata_d = conv_control_zero_q;
                    end
                    default: begin
                        rdata_d = irq_pkg::REG_RST;
                    end
                endcase
            end
        end
    end

    // State registers; reset leaves every enable cleared
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_control_reg_q <= irq_pkg::REG_RST;
            periph_flag_reg_one_q <= irq_pkg::REG_RST;
            periph_enable_reg_one_q <= irq_pkg::REG_RST;
            conv_result_reg_q <= irq_pkg::REG_RST;
            conv_control_zero_q <= irq_pkg::REG_RST;
            rdata_q <= irq_pkg::REG_RST;
            prev_q <= '0;
            start_q <= 1'b0;
            evt_q <= 1'b0;
        end else begin
            irq_control_reg_q <= irq_control_reg_d;
            periph_flag_reg_one_q <= periph_flag_reg_one_d;
            periph_enable_reg_one_q <= periph_enable_reg_one_d;
            conv_result_reg_q <= conv_result_reg_d;
            conv_control_zero_q <= conv_control_zero_d;
            rdata_q <= rdata_d;
            prev_q <= prev_d;
            start_q <= start_d;
            evt_q <= evt_d;
        end
    end

    // Source requests: flag and enable per source
    assign core_req =
        (irq_control_reg_q[irq_pkg::TIMER_EN_BIT]
            & irq_control_reg_q[irq_pkg::TIMER_FLAG_BIT])
        | (irq_control_reg_q[irq_pkg::PIN_EN_BIT]
            & irq_control_reg_q[irq_pkg::PIN_FLAG_BIT])
        | (irq_control_reg_q[irq_pkg::PORT_EN_BIT]
            & irq_control_reg_q[irq_pkg::PORT_FLAG_BIT]);
    // Peripheral source also needs the peripheral enable
    assign periph_req = irq_control_reg_q[irq_pkg::CONV_EN_BIT]
        & periph_enable_reg_one_q[irq_pkg::CONV_FLAG_BIT]
        & periph_flag_reg_one_q[irq_pkg::CONV_FLAG_BIT];
    // Global gate, no other qualification
    assign link.irq_req = irq_control_reg_q[irq_pkg::GLOBAL_EN_BIT]
        & (core_req | periph_req);

    // Link and converter outputs
    assign link.vector = irq_pkg::VECTOR_ADDR;
    assign link.f_rdata = rdata_q;
    assign link.conv_done_evt = evt_q;
    assign conv_start = start_q;
    assign conv_power = conv_control_zero_q[irq_pkg::CONV_ON_BIT];
endmodule

// ---- irq_core_seq.sv ----
// Processor core end: instruction sequencer, stack and software port
module irq_core_seq #(
    parameter int INSTR_CLKS = irq_pkg::INSTR_CLKS,
    parameter int DEPTH = irq_pkg::STACK_DEPTH
) (
    input wire logic mclk,
    input wire logic resetn,
    irq_link_if.core link,
    input wire logic [2:0] usr_addr,
    input wire logic [7:0] usr_wdata,
    input wire logic usr_we,
    input wire logic usr_re,
    output logic [7:0] usr_rdata
);
    localparam int TW = $clog2(INSTR_CLKS + 1);
    localparam int SW = $clog2(DEPTH);
    localparam int GW = $clog2(irq_pkg::GAP_CLKS + 1);
    localparam int PC_W = irq_pkg::PC_W;

    irq_pkg::seq_type seq_q, seq_d;
    irq_pkg::bus_type bus_q, bus_d;
    logic [TW-1:0] tick_q, tick_d;
    logic [1:0] dummy_q, dummy_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [PC_W-1:0] stack_q [DEPTH];
    logic [PC_W-1:0] stack_d [DEPTH];
    logic [SW-1:0] sp_q, sp_d;
    logic [GW-1:0] settle_q, settle_d;
    logic [7:0] faddr_q, faddr_d, fdata_q, fdata_d, hold_q, hold_d;
    logic [7:0] baddr_q, baddr_d, bwdata_q, bwdata_d, urd_q, urd_d;
    logic bwe_q, bwe_d, bre_q, bre_d, cap_q, cap_d;
    logic ack_q, ack_d, ret_q, ret_d, isr_q, isr_d, pend_q, pend_d;
    logic held_q, held_d;
    logic tick, bus_free, wr_go;

    assign tick = tick_q == TW'(INSTR_CLKS - 1);
    assign bus_free = (bus_q == irq_pkg::BS_IDLE) & ~bre_q & ~cap_q & ~held_q;
    assign wr_go = (faddr_q == irq_pkg::CONV_CTRL_ADDR)
        & usr_wdata[irq_pkg::GO_BIT];

    // Instruction sequencing and interrupt acceptance
    always_comb begin
        seq_d = seq_q;
        tick_d = tick ? '0 : tick_q + 1'b1;
        dummy_d = dummy_q;
        pc_d = pc_q;
        stack_d = stack_q;
        sp_d = sp_q;
        ack_d = 1'b0;
        ret_d = 1'b0;
        isr_d = isr_q;
        pend_d = pend_q;
        if (usr_we && usr_addr == irq_pkg::UREG_CTRL
            && usr_wdata[irq_pkg::CTL_RETURN]) begin
            pend_d = 1'b1;
        end
        if (tick) begin
            case (seq_q)
                irq_pkg::SQ_RUN: begin
                    if (link.irq_req) begin
                        // Fetched instruction is dropped and restarted later
                        ack_d = 1'b1;
                        stack_d[sp_q] = pc_q;
                        sp_d = sp_q + 1'b1;
                        dummy_d = 2'(irq_pkg::DUMMY_CYCLES - 1);
                        seq_d = irq_pkg::SQ_DUMMY;
                    end else if (pend_q) begin
                        sp_d = sp_q - 1'b1;
                        pc_d = stack_q[sp_q - 1'b1];
                        ret_d = 1'b1;
                        isr_d = 1'b0;
                        pend_d = 1'b0;
                    end else begin
                        pc_d = pc_q + 1'b1;
                    end
                end
                irq_pkg::SQ_DUMMY: begin
                    if (dummy_q == 2'h0) begin
                        pc_d = link.vector;
                        isr_d = 1'b1;
                        seq_d = irq_pkg::SQ_RUN;
                    end else begin
                        dummy_d = dummy_q - 1'b1;
                    end
                end
                default: begin
                    seq_d = irq_pkg::SQ_RUN;
                end
            endcase
        end
    end

    // File bus: user accesses, held start, safe global disable loop
    always_comb begin
        bus_d = bus_q;
        faddr_d = faddr_q;
        fdata_d = fdata_q;
        hold_d = hold_q;
        held_d = held_q;
        baddr_d = baddr_q;
        bwdata_d = bwdata_q;
        bwe_d = 1'b0;
        bre_d = 1'b0;
        cap_d = bre_q;
        settle_d = settle_q;
        if (link.conv_done_evt) begin
            settle_d = GW'(irq_pkg::GAP_CLKS);
        end else if (settle_q != '0) begin
            settle_d = settle_q - 1'b1;
        end
        if (cap_q && bus_q == irq_pkg::BS_IDLE) begin
            fdata_d = link.f_rdata;
        end
        if (usr_we && usr_addr == irq_pkg::UREG_FADDR) begin
            faddr_d = usr_wdata;
        end
        // Flags are cleared only by software writes through here
        if (usr_we && usr_addr == irq_pkg::UREG_FDATA && bus_free) begin
            if (wr_go && settle_q != '0) begin
                held_d = 1'b1;
                hold_d = usr_wdata;
            end else begin
                bwe_d = 1'b1;
                baddr_d = faddr_q;
                bwdata_d = usr_wdata;
            end
        end
        if (usr_we && usr_addr == irq_pkg::UREG_CTRL && bus_free) begin
            if (usr_wdata[irq_pkg::CTL_SAFE_OFF]) begin
                bus_d = irq_pkg::BS_READ;
            end else if (usr_wdata[irq_pkg::CTL_READ]) begin
                bre_d = 1'b1;
                baddr_d = faddr_q;
            end
        end
        // Start held back until the settle time has run out
        if (held_q && settle_q == '0 && bus_q == irq_pkg::BS_IDLE) begin
            bwe_d = 1'b1;
            baddr_d = irq_pkg::CONV_CTRL_ADDR;
            bwdata_d = hold_q;
            held_d = 1'b0;
        end
        case (bus_q)
            irq_pkg::BS_IDLE: begin
                bus_d = bus_d;
            end
            irq_pkg::BS_READ: begin
                bre_d = 1'b1;
                baddr_d = irq_pkg::IRQ_CTRL_LO_ADDR;
                bus_d = irq_pkg::BS_WAIT;
            end
            irq_pkg::BS_WAIT: begin
                bus_d = irq_pkg::BS_CHECK;
            end
            irq_pkg::BS_CHECK: begin
                // Clear, then test again until it reads cleared
                if (link.f_rdata[irq_pkg::GLOBAL_EN_BIT]) begin
                    bwe_d = 1'b1;
                    bwdata_d = link.f_rdata;
                    bwdata_d[irq_pkg::GLOBAL_EN_BIT] = 1'b0;
                    bus_d = irq_pkg::BS_READ;
                end else begin
                    bus_d = irq_pkg::BS_IDLE;
                end
            end
            default: begin
                bus_d = irq_pkg::BS_IDLE;
            end
        endcase
    end

    // User register read, valid only the cycle after the strobe
    always_comb begin
        urd_d = 8'h00;
        if (usr_re) begin
            case (usr_addr)
                irq_pkg::UREG_FADDR: urd_d = faddr_q;
                irq_pkg::UREG_FDATA: urd_d = fdata_q;
                irq_pkg::UREG_STATUS: begin
                    urd_d = {2'h0, ~bus_free, pend_q, held_q,
                        settle_q != '0, seq_q == irq_pkg::SQ_DUMMY, isr_q};
                end
                irq_pkg::UREG_PC_LO: urd_d = pc_q[7:0];
                irq_pkg::UREG_PC_HI: urd_d = {3'h0, pc_q[PC_W-1:8]};
                default: urd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            seq_q <= irq_pkg::SQ_RUN;
            bus_q <= irq_pkg::BS_IDLE;
            tick_q <= '0;
            dummy_q <= 2'h0;
            pc_q <= irq_pkg::PC_RST;
            stack_q <= '{default: irq_pkg::PC_RST};
            sp_q <= '0;
            settle_q <= '0;
            faddr_q <= 8'h00;
            fdata_q <= 8'h00;
            hold_q <= 8'h00;
            baddr_q <= 8'h00;
            bwdata_q <= 8'h00;
            urd_q <= 8'h00;
            {bwe_q, bre_q, cap_q, ack_q, ret_q} <= 5'h00;
            {isr_q, pend_q, held_q} <= 3'h0;
        end else begin
            seq_q <= seq_d;
            bus_q <= bus_d;
            tick_q <= tick_d;
            dummy_q <= dummy_d;
            pc_q <= pc_d;
            stack_q <= stack_d;
            sp_q <= sp_d;
            settle_q <= settle_d;
            faddr_q <= faddr_d;
            fdata_q <= fdata_d;
            hold_q <= hold_d;
            baddr_q <= baddr_d;
            bwdata_q <= bwdata_d;
            urd_q <= urd_d;
            {bwe_q, bre_q, cap_q, ack_q, ret_q} <=
                {bwe_d, bre_d, cap_d, ack_d, ret_d};
            {isr_q, pend_q, held_q} <= {isr_d, pend_d, held_d};
        end
    end

    assign link.f_addr = baddr_q;
    assign link.f_wdata = bwdata_q;
    assign link.f_we = bwe_q;
    assign link.f_re = bre_q;
    assign link.irq_ack = ack_q;
    assign link.isr_return = ret_q;
    assign usr_rdata = urd_q;
endmodule

// ---- irq_link_chk.sv ----
// Link checker: request, acknowledge and file bus timing
module irq_link_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] f_rdata,
    input wire logic f_we,
    input wire logic f_re,
    input wire logic irq_req,
    input wire logic irq_ack,
    input wire logic [irq_pkg::PC_W-1:0] vector
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Vector and request relations
    property p_vec; vector == 13'h0004; endproperty
    a_vec: assert property (p_vec) else $error("vector moved");
    property p_rst; !$past(resetn) |-> !irq_req; endproperty
    a_rst: assert property (p_rst) else $error("request at reset");
    property p_cause; irq_ack |-> $past(irq_req); endproperty
    a_cause: assert property (p_cause) else $error("ack uncaused");
    property p_clr; irq_ack |=> !irq_req; endproperty
    a_clr: assert property (p_clr) else $error("enable kept");
    property p_gap; irq_ack |=> !irq_ack [*8]; endproperty
    a_gap: assert property (p_gap) else $error("ack too soon");
    property p_take; $rose(irq_req) |-> ##[1:6] (irq_ack || !irq_req);
    endproperty
    a_take: assert property (p_take) else $error("request ignored");
    // File bus relations
    property p_strb; !(f_we && f_re); endproperty
    a_strb: assert property (p_strb) else $error("both strobes");
    property p_idle; !$past(f_re) |-> f_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data stale");
endmodule

// ---- mcu_interrupt_logic_with_adc_done_tb_top.sv ----
// Bench joining the controller and the core over the link
module mcu_interrupt_logic_with_adc_done_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic ext_irq_pin = 1'b0;
    logic [3:0] port_b_upper_pins = 4'h0;
    logic timer_ovf = 1'b0;
    logic conv_done = 1'b0;
    logic [7:0] conv_result = 8'h00;
    logic [2:0] usr_addr = 3'h0;
    logic [7:0] usr_wdata = 8'h00;
    logic usr_we = 1'b0;
    logic usr_re = 1'b0;
    logic [7:0] usr_rdata;
    logic conv_start;
    logic conv_power;
    logic [7:0] r;
    logic [7:0] res;
    logic [7:0] en;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_ack = 0;
    int n_start = 0;
    int seed = 32'h66cf;
    irq_link_if link();
    irq_ctrl_dev u_irq_ctrl_dev(.mclk(mclk), .resetn(resetn), .link(link),
        .ext_irq_pin(ext_irq_pin), .port_b_upper_pins(port_b_upper_pins),
        .timer_ovf(timer_ovf), .conv_done(conv_done),
        .conv_result(conv_result), .conv_start(conv_start),
        .conv_power(conv_power));
    irq_core_seq u_irq_core_seq(.mclk(mclk), .resetn(resetn), .link(link),
        .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_we(usr_we),
        .usr_re(usr_re), .usr_rdata(usr_rdata));
    irq_link_chk u_irq_link_chk(.mclk(mclk), .resetn(resetn),
        .f_rdata(link.f_rdata), .f_we(link.f_we), .f_re(link.f_re),
        .irq_req(link.irq_req), .irq_ack(link.irq_ack),
        .vector(link.vector));
    always #2.5 mclk = ~mclk;
    // Count accepted interrupts
    always @(posedge mclk) if (link.irq_ack === 1'b1) n_ack++;
    // Count conversion start pulses
    always @(posedge mclk) if (conv_start === 1'b1) n_start++;
    // Expected request from control, periph enable and periph flag
    function automatic logic req_exp(input logic [7:0] c,
            input logic pe, input logic pf);
        return c[7] & ((|(c[5:3] & c[2:0])) | (c[6] & pe & pf));
    endfunction
    task automatic chk8(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One user port cycle, write or read
    task automatic ucyc(input logic [2:0] a, input logic [7:0] d,
            input logic we);
        @(posedge mclk);
        usr_addr <= a;
        usr_wdata <= d;
        usr_we <= we;
        usr_re <= !we;
        @(posedge mclk);
        usr_we <= 1'b0;
        usr_re <= 1'b0;
        #1;
        r = usr_rdata;
    endtask
    task automatic lwr(input logic [7:0] a, input logic [7:0] d);
        ucyc(irq_pkg::UREG_FADDR, a, 1'b1);
        ucyc(irq_pkg::UREG_FDATA, d, 1'b1);
        repeat (2) @(posedge mclk);
    endtask
    task automatic lrd(input logic [7:0] a);
        ucyc(irq_pkg::UREG_FADDR, a, 1'b1);
        ucyc(irq_pkg::UREG_CTRL, 8'h01, 1'b1);
        repeat (4) @(posedge mclk);
        ucyc(irq_pkg::UREG_FDATA, 8'h00, 1'b0);
    endtask
    // Raise one source: 0 port, 1 pin, 2 timer, 3 conversion
    task automatic fire(input int i);
        @(posedge mclk);
        case (i)
            0: port_b_upper_pins <= port_b_upper_pins ^ 4'($random(seed) | 1);
            1: ext_irq_pin <= 1'b1;
            2: timer_ovf <= 1'b1;
            default: begin
                res = 8'($random(seed));
                conv_done <= 1'b1;
                conv_result <= res;
            end
        endcase
        @(posedge mclk);
        timer_ovf <= 1'b0;
        conv_done <= 1'b0;
        repeat (8) @(posedge mclk);
        ext_irq_pin <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    task automatic wait_ack(input int want);
        for (int k = 0; k < 60 && n_ack != want; k++) @(negedge mclk);
        if (n_ack != want) begin
            chk8("ack count", 8'(want), 8'(n_ack));
            finish_test();
        end
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        lrd(8'h0b);
        chk8("ctrl reset", 8'h00, r);
        lrd(8'h20);
        chk8("unmapped", 8'h00, r);
        lwr(8'h1f, 8'h05);
        chk8("power", 8'h01, 8'(conv_power));
        for (int i = 0; i < 4; i++) fire(i);
        lrd(8'h0b);
        chk8("flags masked", 8'h07, r);
        lrd(8'h8b);
        chk8("mirror", 8'h07, r);
        lrd(8'h0c);
        chk8("periph flag", 8'h40, r);
        lrd(8'h1e);
        chk8("result", res, r);
        lrd(8'h1f);
        chk8("go cleared", 8'h01, r);
        chk8("starts", 8'h01, 8'(n_start));
        chk8("req off", 8'(req_exp(8'h07, 0, 1)), 8'(link.irq_req));
        $display("flag test done");
        lwr(8'h0b, 8'h00);
        lwr(8'h0c, 8'h00);
        lwr(8'h8c, 8'h40);
        // Each source taken alone through the vector
        for (int i = 0; i < 4; i++) begin
            en = 8'h08 << i;
            lwr(8'h0b, 8'h80 | en);
            fire(i);
            wait_ack(i + 1);
            repeat (12) @(posedge mclk);
            ucyc(irq_pkg::UREG_STATUS, 8'h00, 1'b0);
            chk8("in service", 8'h01, {7'h0, r[0]});
            lrd(8'h0b);
            chk8("ctrl in isr", en | (i < 3 ? 8'h01 << i : 8'h00), r);
            lwr(8'h0b, en);
            lwr(8'h0c, 8'h00);
            ucyc(irq_pkg::UREG_CTRL, 8'h02, 1'b1);
            repeat (12) @(posedge mclk);
            lrd(8'h0b);
            chk8("ctrl returned", 8'h80 | en, r);
            chk8("acks", 8'(i + 1), 8'(n_ack));
            $display("source %0d test done", i);
        end
        // Safe global disable loop leaves enables, clears global
        ucyc(irq_pkg::UREG_CTRL, 8'h04, 1'b1);
        repeat (12) @(posedge mclk);
        lrd(8'h0b);
        chk8("safe off", en, r);
        // Start inside the settle time is held until it runs out
        lwr(8'h1f, 8'h05);
        chk8("start held", 8'h01, 8'(n_start));
        ucyc(irq_pkg::UREG_STATUS, 8'h00, 1'b0);
        chk8("held", 8'h08, r & 8'h08);
        repeat (irq_pkg::GAP_CLKS) @(posedge mclk);
        chk8("start late", 8'h02, 8'(n_start));
        $display("settle test done");
        // Global enable off blocks, then on takes it
        lwr(8'h0b, 8'h78);
        fire(2);
        chk8("req blocked", 8'(req_exp(8'h7c, 1, 0)), 8'(link.irq_req));
        lwr(8'h0b, 8'hfc);
        wait_ack(5);
        $display("global test done");
        finish_test();
    end
endmodule
